// ==== hw/lsc_link.sv ====
// How it works
// R1: asleep, a falling bus edge then dominant longer than the wake filter time is a wake-up.
// R2: after wake-up, the next rising edge launches a power-on reset; normal mode starts once it ends.
// R3: the power-on reset ends within 5 ms of that edge; frames before then are ignored.
// R4: supply below the extended minimum blocks the link until above the wake threshold.
// R5: driver overheat turns the driver off and the link becomes receive-only.
// R6: after cooling, the driver stays off until the block itself starts a dominant-to-recessive step.
// R7: no diagnostic field ever carries the driver overheat event.
// R8: in normal mode, recessive idle longer than the idle timeout sends the device to sleep.
// R9: every frame's sync field is re-measured to set the bit clock for that frame.
// R10: in programming mode the bit timing runs at the flash rate.
// R11: the block acts on a header, or answers, only after the header is received.
// R12: high is recessive (1), low dominant (0); the bus is left recessive when idle.
// R13: response bytes go out only on request; otherwise received bytes go into the buffer.
// R14: in sleep the receiver is off and only the wake detector watches the bus.
// R15: each byte is one start bit, 8 data bits lsb first, one stop bit.
// R16: recessive longer than the bus timeout inside a frame resets the receiver and drops the frame.
// R17: wake filter and idle timeout are counters cleared when the bus leaves the timed level.
`timescale 1ns/100ps
`default_nettype none
module lsc_link
  import lsc_pkg::*;
#(
  parameter int unsigned START_CYCLES = START_CYC,
  parameter int unsigned IDLE_CYCLES  = IDLE_CYC,
  parameter int unsigned TMO_CYCLES   = BUS_TMO_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        bus_rx_i,
  output logic             bus_tx_o,
  output logic             bus_tx_oe_o,
  output logic             term_on_o,
  input  wire logic        supply_low_i,
  input  wire logic        supply_wake_ok_i,
  input  wire logic        driver_overheat_i,
  input  wire logic        prog_mode_i,
  input  wire logic        sleep_cmd_i,
  input  wire logic        hdr_done_i,
  input  wire logic        resp_req_i,
  input  wire logic [7:0]  resp_data_i,
  input  wire logic        resp_valid_i,
  output logic             resp_ready_o,
  output logic [7:0]       rx_data_o,
  output logic             rx_valid_o,
  input  wire logic        rx_ready_i,
  output logic             frame_start_o,
  output logic             awake_o,
  output logic             por_o,
  output logic             rx_enabled_o,
  output logic [BIT_W-1:0] bit_cycles_o,
  output logic             diag_flag_o
);
  lsc_mode_t        mode, next_mode;
  lsc_rx_t          rxs, next_rxs;
  logic             bus_q, next_bus_q;
  logic             drv_block, next_drv_block;
  logic [BIT_W-1:0] bit_len, next_bit_len;
  logic [BIT_W+3:0] meas, next_meas;
  logic [BIT_W-1:0] bcnt, next_bcnt;
  logic [3:0]       bidx, next_bidx;
  logic [3:0]       edges, next_edges;
  logic [7:0]       shreg, next_shreg;
  logic [7:0]       rx_byte, next_rx_byte;
  logic             rx_push, next_rx_push;
  logic             tx_bit, next_tx_bit;
  logic             tx_pop, next_tx_pop;
  logic             fstart, next_fstart;
  logic             fall, rise, in_frame;
  logic             wake_exp, por_exp, idle_exp, tmo_exp, brk_exp;
  logic             fifo_in_ready, fifo_flush;
  logic             clr_wake, clr_por, clr_idle, clr_tmo, clr_brk;

  ////////////////////////////////////////////////////////////////////////////
  // timers
  always_comb begin
    fall     = bus_q && !bus_rx_i;
    rise     = !bus_q && bus_rx_i;
    in_frame = (rxs != LSC_R_IDLE);
    clr_wake = bus_rx_i || (mode != LSC_WAKE);                       // [R17]
    clr_idle = !bus_rx_i || in_frame || (mode != LSC_NORMAL);        // [R17]
    clr_por  = (mode != LSC_POR);
    clr_tmo  = !bus_rx_i || !in_frame || (rxs == LSC_R_TX);
    clr_brk  = bus_rx_i || (mode != LSC_NORMAL);
  end

  lsc_timer #(.W(CNT_W)) u_wake (.clk_i(clk_i), .rst_b_i(rst_b_i), .clear_i(clr_wake),
    .limit_i(CNT_W'(WAKE_FILT_CYC)), .expired_o(wake_exp));
  lsc_timer #(.W(CNT_W)) u_por (.clk_i(clk_i), .rst_b_i(rst_b_i), .clear_i(clr_por),
    .limit_i(CNT_W'(START_CYCLES)), .expired_o(por_exp));
  lsc_timer #(.W(CNT_W)) u_idle (.clk_i(clk_i), .rst_b_i(rst_b_i), .clear_i(clr_idle),
    .limit_i(CNT_W'(IDLE_CYCLES)), .expired_o(idle_exp));
  lsc_timer #(.W(CNT_W)) u_tmo (.clk_i(clk_i), .rst_b_i(rst_b_i), .clear_i(clr_tmo),
    .limit_i(CNT_W'(TMO_CYCLES)), .expired_o(tmo_exp));
  lsc_timer #(.W(CNT_W)) u_brk (.clk_i(clk_i), .rst_b_i(rst_b_i), .clear_i(clr_brk),
    .limit_i(CNT_W'(BREAK_BITS) * CNT_W'(bit_len)), .expired_o(brk_exp));

  ////////////////////////////////////////////////////////////////////////////
  // operating mode
  always_comb begin
    next_mode = mode;
    case (mode)
      LSC_SLEEP: begin
        if (fall) begin
          next_mode = LSC_WAKE;                                      // [R1]
        end
      end
      LSC_WAKE: begin
        if (wake_exp) begin
          next_mode = LSC_WAITUP;                                    // [R1]
        end else if (bus_rx_i) begin
          next_mode = LSC_SLEEP;
        end
      end
      LSC_WAITUP: begin
        if (rise) begin
          next_mode = LSC_POR;                                       // [R2]
        end
      end
      LSC_POR: begin
        if (por_exp) begin
          next_mode = LSC_NORMAL;                                    // [R3]
        end
      end
      LSC_NORMAL: begin
        if (supply_low_i) begin
          next_mode = LSC_UV;                                        // [R4]
        end else if (idle_exp || sleep_cmd_i) begin
          next_mode = LSC_SLEEP;                                     // [R8]
        end
      end
      LSC_UV: begin
        if (supply_wake_ok_i && !supply_low_i) begin
          next_mode = LSC_NORMAL;                                    // [R4]
        end
      end
      default: next_mode = LSC_SLEEP;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver, sync measurement and responder
  always_comb begin
    next_rxs       = rxs;
    next_bus_q     = bus_rx_i;
    next_bit_len   = bit_len;
    next_meas      = meas;
    next_bcnt      = bcnt;
    next_bidx      = bidx;
    next_edges     = edges;
    next_shreg     = shreg;
    next_rx_byte   = rx_byte;
    next_rx_push   = 1'b0;
    next_tx_bit    = tx_bit;
    next_tx_pop    = 1'b0;
    next_fstart    = 1'b0;
    next_drv_block = drv_block;
    if (rxs == LSC_R_IDLE) begin
      // nominal rate between frames; each sync then measures its own
      next_bit_len = prog_mode_i ? BIT_W'(BIT_FLASH_CYC) : BIT_W'(BIT_NORM_CYC); // [R10]
    end
    if (driver_overheat_i) begin
      next_drv_block = 1'b1;                                         // [R5]
    end
    if (mode != LSC_NORMAL || tmo_exp) begin
      next_rxs    = LSC_R_IDLE;                                      // [R14] [R16]
      next_tx_bit = 1'b1;
    end else if (brk_exp) begin
      next_rxs    = LSC_R_BRK;                                       // break restarts receiver
      next_tx_bit = 1'b1;
    end else begin
      case (rxs)
        LSC_R_IDLE: begin
          if (brk_exp) begin
            next_rxs = LSC_R_BRK;
          end
        end
        LSC_R_BRK: begin
          if (rise) begin
            next_rxs   = LSC_R_SYNC;
            next_edges = '0;
            next_meas  = '0;
          end
        end
        LSC_R_SYNC: begin
          next_meas = meas + 1'b1;
          if (fall) begin
            next_edges = edges + 1'b1;
            if (edges == '0) begin
              next_meas = '0;
            end else if (edges == SYNC_EDGES) begin
              next_bit_len = BIT_W'(meas >> 3);                      // [R9]
              next_fstart  = 1'b1;
              next_rxs     = LSC_R_BYTE;
              next_bidx    = '0;
              next_bcnt    = BIT_W'(meas >> 3) + BIT_W'(meas >> 4);  // skip to mid sync stop
            end
          end
        end
        LSC_R_BYTE: begin
          if (bidx == '0 && bcnt == '0 && bus_rx_i) begin
            next_bcnt = '0;                                          // wait for start bit
            if (hdr_done_i && resp_req_i && resp_valid_i) begin
              next_rxs   = LSC_R_TX;                                 // [R11] [R13]
              next_shreg = resp_data_i;
              next_tx_pop = 1'b1;
              next_tx_bit = 1'b0;                                    // [R15]
              next_bcnt  = bit_len;
            end
          end else if (bcnt != '0) begin
            next_bcnt = bcnt - 1'b1;
          end else begin
            next_bcnt = bit_len;
            if (bidx == STOP_BIT) begin
              next_bidx = '0;
              next_bcnt = '0;
              if (bus_rx_i && !(hdr_done_i && resp_req_i)) begin
                next_rx_byte = shreg;                                // [R13]
                next_rx_push = 1'b1;
              end
            end else begin
              next_bidx = bidx + 1'b1;
              if (bidx != '0) begin
                next_shreg = {bus_rx_i, shreg[7:1]};                 // [R15]
              end
            end
          end
          if (fall && bidx == '0 && bcnt == '0) begin
            next_bcnt = BIT_W'(bit_len >> 1);
            next_bidx = '0;                                          // first look is mid start
          end
        end
        LSC_R_TX: begin
          if (bcnt != '0) begin
            next_bcnt = bcnt - 1'b1;
          end else begin
            next_bcnt = bit_len;
            next_bidx = bidx + 1'b1;
            if (bidx == LAST_DATA_BIT) begin
              next_tx_bit = 1'b1;                                    // [R15]
              if (!tx_bit) begin
                next_drv_block = driver_overheat_i;                  // [R6]
              end
            end else if (bidx == STOP_BIT) begin
              next_rxs  = LSC_R_BYTE;
              next_bidx = '0;
              next_bcnt = '0;
            end else begin
              next_tx_bit = shreg[bidx[2:0]];
              if (!tx_bit && shreg[bidx[2:0]]) begin
                next_drv_block = driver_overheat_i;                  // [R6]
              end
            end
          end
        end
        default: next_rxs = LSC_R_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mode      <= LSC_NORMAL;
      rxs       <= LSC_R_IDLE;
      bus_q     <= 1'b1;
      drv_block <= 1'b0;
      bit_len   <= BIT_W'(BIT_NORM_CYC);
      meas      <= '0;
      bcnt      <= '0;
      bidx      <= '0;
      edges     <= '0;
      shreg     <= '0;
      rx_byte   <= '0;
      rx_push   <= 1'b0;
      tx_bit    <= 1'b1;
      tx_pop    <= 1'b0;
      fstart    <= 1'b0;
    end else begin
      mode      <= next_mode;
      rxs       <= next_rxs;
      bus_q     <= next_bus_q;
      drv_block <= next_drv_block;
      bit_len   <= next_bit_len;
      meas      <= next_meas;
      bcnt      <= next_bcnt;
      bidx      <= next_bidx;
      edges     <= next_edges;
      shreg     <= next_shreg;
      rx_byte   <= next_rx_byte;
      rx_push   <= next_rx_push;
      tx_bit    <= next_tx_bit;
      tx_pop    <= next_tx_pop;
      fstart    <= next_fstart;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // received data buffer; a full buffer drops the byte
  always_comb begin
    fifo_flush = (mode != LSC_NORMAL);
  end

  lsc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .flush_i    (fifo_flush),
    .in_data_i  (rx_byte),
    .in_valid_i (rx_push),
    .in_ready_o (fifo_in_ready),
    .out_data_o (rx_data_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  // outputs decoded from flops only, no input reaches them
  always_comb begin
    bus_tx_o     = tx_bit;                                           // [R12]
    bus_tx_oe_o  = (rxs == LSC_R_TX) && !tx_bit && !drv_block;       // [R5] [R12]
    term_on_o    = (mode == LSC_NORMAL) || (mode == LSC_UV);         // [R4]
    resp_ready_o = tx_pop;
    frame_start_o = fstart;
    awake_o      = (mode == LSC_NORMAL);
    por_o        = (mode == LSC_POR);
    rx_enabled_o = (rxs != LSC_R_IDLE) && fifo_in_ready && (mode == LSC_NORMAL); // [R14]
    bit_cycles_o = bit_len;
    diag_flag_o  = 1'b0;                                             // [R7]
  end
endmodule // lsc_link
`default_nettype wire

// ==== hw/lsc_pkg.sv ====
package lsc_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned WAKE_FILT_US    = 30;      // least dominant time for wake
  localparam int unsigned WAKE_FILT_CYC   = (WAKE_FILT_US * (CLK_HZ / 1_000_000)) + 1;
  localparam int unsigned START_MS        = 5;       // longest start-up time
  localparam int unsigned START_CYC       = START_MS * (CLK_HZ / 1_000);
  localparam int unsigned BUS_TMO_MS      = 9;       // recessive timeout inside a frame
  localparam int unsigned BUS_TMO_CYC     = BUS_TMO_MS * (CLK_HZ / 1_000);
  localparam int unsigned IDLE_S          = 8;       // idle timeout between frames
  localparam int unsigned IDLE_CYC        = IDLE_S * CLK_HZ;
  localparam int unsigned BAUD_NORM       = 19_200;  // nominal normal-mode rate
  localparam int unsigned BAUD_FLASH      = 115_000; // flash-mode rate
  localparam int unsigned BIT_NORM_CYC    = CLK_HZ / BAUD_NORM;
  localparam int unsigned BIT_FLASH_CYC   = CLK_HZ / BAUD_FLASH;
  localparam int unsigned BREAK_BITS      = 11;      // dominant bits marking a break
  // widths
  localparam int unsigned CNT_W           = 32;
  localparam int unsigned BIT_W           = 16;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned FIFO_DEPTH      = 32;
  localparam logic [7:0]  SYNC_BYTE       = 8'h55;
  localparam logic [3:0]  SYNC_EDGES      = 4'h4;    // fifth fall of the sync byte closes 8 bits
  localparam logic [3:0]  LAST_DATA_BIT   = 4'h8;
  localparam logic [3:0]  STOP_BIT        = 4'h9;

  typedef enum logic [5:0] {
    LSC_SLEEP   = 6'h01,
    LSC_WAKE    = 6'h02,
    LSC_WAITUP  = 6'h04,
    LSC_POR     = 6'h08,
    LSC_NORMAL  = 6'h10,
    LSC_UV      = 6'h20
  } lsc_mode_t;

  typedef enum logic [4:0] {
    LSC_R_IDLE  = 5'h01,
    LSC_R_BRK   = 5'h02,
    LSC_R_SYNC  = 5'h04,
    LSC_R_BYTE  = 5'h08,
    LSC_R_TX    = 5'h10
  } lsc_rx_t;
endpackage : lsc_pkg

// ==== hw/lsc_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module lsc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             flush_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush_i) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_comb begin
    in_ready_o  = (count != DEPTH[AW:0]);
    out_valid_o = (count != '0);
    out_data_o  = mem[rd_ptr];
  end
endmodule // lsc_fifo
`default_nettype wire

// ==== hw/lsc_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
// up-counter that reports once a limit is passed; cleared on demand
module lsc_timer #(
  parameter int unsigned W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         clear_i,
  input  wire logic [W-1:0] limit_i,
  output logic              expired_o
);
  logic [W-1:0] cnt, next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (clear_i) begin
      next_cnt = '0;
    end else if (cnt < limit_i) begin
      next_cnt = cnt + 1'b1;
    end
    expired_o = (cnt >= limit_i) && !clear_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule // lsc_timer
`default_nettype wire

// ==== tb/lsc_link_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module lsc_link_chk
  import lsc_pkg::*;
#(
  parameter int unsigned START_CYCLES = START_CYC,
  parameter int unsigned IDLE_CYCLES  = IDLE_CYC,
  parameter int unsigned TMO_CYCLES   = BUS_TMO_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic bus_rx_i,
  input wire logic bus_tx_o,
  input wire logic bus_tx_oe_o,
  input wire logic term_on_o,
  input wire logic supply_low_i,
  input wire logic driver_overheat_i,
  input wire logic hdr_done_i,
  input wire logic resp_req_i,
  input wire logic resp_ready_o,
  input wire logic awake_o,
  input wire logic por_o,
  input wire logic rx_enabled_o,
  input wire logic diag_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [31:0] por_cnt;
  logic [31:0] idle_cnt;
  logic [31:0] dom_cnt;
  logic [31:0] last_run;
  logic        hold_off;
  logic        prev_tx;
  ////////////////////////////////////////////////////////////////////////
  // run lengths too long for repetition, so plain counters
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      por_cnt  <= '0;
      idle_cnt <= '0;
      dom_cnt  <= '0;
      last_run <= '0;
      hold_off <= 1'b0;
      prev_tx  <= 1'b1;
    end else begin
      por_cnt  <= por_o ? por_cnt + 1 : '0;
      idle_cnt <= (awake_o && bus_rx_i) ? idle_cnt + 1 : '0;
      dom_cnt  <= bus_rx_i ? '0 : dom_cnt + 1;
      last_run <= (bus_rx_i && dom_cnt != 0) ? dom_cnt : last_run;
      prev_tx  <= bus_tx_o;
      // cleared only by the block's own 0 to 1 bit step
      hold_off <= driver_overheat_i | (hold_off & ~(bus_tx_o & ~prev_tx));
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_oe_pol; bus_tx_oe_o |-> !bus_tx_o; endproperty
  a_oe_pol: assert property (p_oe_pol) else $error("driver on with recessive bit");
  property p_hot_off; driver_overheat_i |=> !bus_tx_oe_o; endproperty
  a_hot_off: assert property (p_hot_off) else $error("driver on while hot");
  property p_cool_hold; hold_off |-> !bus_tx_oe_o; endproperty
  a_cool_hold: assert property (p_cool_hold) else $error("driver back before bit step");
  property p_no_diag; !diag_flag_o; endproperty
  a_no_diag: assert property (p_no_diag) else $error("diag flag raised");
  property p_resp_cause; resp_ready_o |-> $past(hdr_done_i) && $past(resp_req_i); endproperty
  a_resp_cause: assert property (p_resp_cause) else $error("byte taken unasked");
  property p_sleep_rx; !awake_o |-> !rx_enabled_o; endproperty
  a_sleep_rx: assert property (p_sleep_rx) else $error("receiver on while not awake");
  property p_por_len; por_cnt <= START_CYCLES + 2; endproperty
  a_por_len: assert property (p_por_len) else $error("start-up too long");
  property p_idle; idle_cnt <= IDLE_CYCLES + TMO_CYCLES + 8; endproperty
  a_idle: assert property (p_idle) else $error("no sleep after idle");
  property p_wake; $rose(por_o) |-> bus_rx_i && (last_run >= WAKE_FILT_CYC - 3); endproperty
  a_wake: assert property (p_wake) else $error("wake without long dominant");
  property p_uv_term; supply_low_i && awake_o |=> term_on_o [*2]; endproperty
  a_uv_term: assert property (p_uv_term) else $error("termination off in undervoltage");
endmodule // lsc_link_chk

bind lsc_link lsc_link_chk #(
  .START_CYCLES(START_CYCLES), .IDLE_CYCLES(IDLE_CYCLES), .TMO_CYCLES(TMO_CYCLES)
) u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_rx_i(bus_rx_i), .bus_tx_o(bus_tx_o),
  .bus_tx_oe_o(bus_tx_oe_o), .term_on_o(term_on_o), .supply_low_i(supply_low_i),
  .driver_overheat_i(driver_overheat_i), .hdr_done_i(hdr_done_i), .resp_req_i(resp_req_i),
  .resp_ready_o(resp_ready_o), .awake_o(awake_o), .por_o(por_o),
  .rx_enabled_o(rx_enabled_o), .diag_flag_o(diag_flag_o)
);
`default_nettype wire

// ==== tb/lsc_master_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module lsc_master_model #(
  parameter int unsigned BIT_CYC = 434
) (
  input  wire logic clk_i,
  output logic      bus_o
);
  initial bus_o = 1'b1; // idle master leaves the line recessive
  ////////////////////////////////////////////////////////////////////////
  // entered and left just after an edge, so changes never meet a sample
  task automatic hold(input logic lvl, input int unsigned n);
    bus_o = lvl;
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // every exchange opens with a break and a delimiter
  task automatic send_break(input int unsigned n);
    hold(1'b0, n);
    hold(1'b1, BIT_CYC);
  endtask
  // start, 8 data lsb first, stop
  task automatic send_byte(input logic [7:0] b);
    hold(1'b0, BIT_CYC);
    for (int i = 0; i < 8; i++)
      hold(b[i], BIT_CYC);
    hold(1'b1, BIT_CYC);
  endtask
endmodule // lsc_master_model
`default_nettype wire

// ==== tb/tb_lsc_link.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_lsc_link
  import lsc_pkg::*;
;
  localparam int unsigned P  = BIT_FLASH_CYC;
  localparam int unsigned ST = 200;
  localparam int unsigned ID = 8000;
  localparam int unsigned TO = 2000;
  logic       clk = 1'b0, rst_b = 1'b0, sup_low = 1'b0, wake_ok = 1'b1, hot = 1'b0;
  logic       prog = 1'b0, sleep_cmd = 1'b0, hdr_done = 1'b0, resp_req = 1'b0;
  logic       resp_valid = 1'b1, rx_ready = 1'b0;
  logic [7:0] resp_data = 8'h35;
  logic       m_bus, tx, oe, term, resp_ready, rx_valid, frame_start, awake, por, rx_en, diag;
  logic [7:0] rx_data;
  logic [BIT_W-1:0] bit_cyc;
  int         err_count = 0, n_compared = 0, fs_cnt = 0, rr_cnt = 0, oe_cnt = 0;
  wire        bus_line = m_bus & ~oe; // released line is pulled recessive

  always #10 clk = ~clk;
  always @(posedge clk) begin
    fs_cnt += frame_start;
    rr_cnt += resp_ready;
    oe_cnt += oe;
  end

  lsc_master_model #(.BIT_CYC(P)) m (.clk_i(clk), .bus_o(m_bus));
  lsc_link #(.START_CYCLES(ST), .IDLE_CYCLES(ID), .TMO_CYCLES(TO)) dut (
    .clk_i(clk), .rst_b_i(rst_b), .bus_rx_i(bus_line), .bus_tx_o(tx), .bus_tx_oe_o(oe),
    .term_on_o(term), .supply_low_i(sup_low), .supply_wake_ok_i(wake_ok),
    .driver_overheat_i(hot), .prog_mode_i(prog), .sleep_cmd_i(sleep_cmd),
    .hdr_done_i(hdr_done), .resp_req_i(resp_req), .resp_data_i(resp_data),
    .resp_valid_i(resp_valid), .resp_ready_o(resp_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .frame_start_o(frame_start),
    .awake_o(awake), .por_o(por), .rx_enabled_o(rx_en), .bit_cycles_o(bit_cyc),
    .diag_flag_o(diag)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int unsigned n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic pop(input logic [7:0] exp);
    int k;
    for (k = 0; k < 50 && rx_valid !== 1'b1; k++) tick(1);
    chk("rx_data", exp, rx_data);
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
    tick(1);
  endtask
  task automatic header(); // break length follows the current bit length
    m.send_break(11 * bit_cyc + 2 * P);
    m.send_byte(SYNC_BYTE);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("tx", 1, tx);
    chk("oe", 0, oe);
    chk("awake", 1, awake);
    chk("diag", 0, diag);
    chk("bit_cycles", BIT_NORM_CYC, bit_cyc);
    prog = 1'b1;
    tick(2);
    chk("bit_cycles_flash", BIT_FLASH_CYC, bit_cyc);
    $display("done: reset");
  endtask
  task automatic t_frame();
    int rr0, oe0, fs0;
    rr0 = rr_cnt;
    oe0 = oe_cnt;
    fs0 = fs_cnt;
    header();
    chk("frame_start", fs0 + 1, fs_cnt);
    chk("bit_in_tol", 1, bit_cyc * 50 >= P * 49 && bit_cyc * 50 <= P * 51);
    m.send_byte(8'h35);
    m.send_byte(8'hca);
    pop(8'h35);
    pop(8'hca);
    chk("unasked_resp", rr0, rr_cnt);
    chk("unasked_drive", oe0, oe_cnt);
    $display("done: frame");
  endtask
  task automatic t_resp();
    logic [7:0] got;
    int k, oe0;
    header();
    m.send_byte(8'h35);
    pop(8'h35);
    resp_data = 8'hca;
    hdr_done = 1'b1;
    resp_req = 1'b1;
    for (k = 0; k < 2000 && oe !== 1'b1; k++) tick(1);
    tick(P + P / 2);
    hdr_done = 1'b0;
    resp_req = 1'b0;
    resp_valid = 1'b0;
    for (k = 0; k < 8; k++) begin
      got[k] = bus_line;
      tick(P);
    end
    chk("resp_byte", 8'hca, got);
    chk("resp_stop", 1, bus_line);
    // a waiting byte must not reach the wire while hot
    hot = 1'b1;
    resp_valid = 1'b1;
    hdr_done = 1'b1;
    resp_req = 1'b1;
    oe0 = oe_cnt;
    for (k = 0; k < 2000 && resp_ready !== 1'b1; k++) tick(1);
    chk("resp_taken_hot", 1, resp_ready);
    resp_valid = 1'b0;
    hdr_done = 1'b0;
    resp_req = 1'b0;
    tick(11 * P);
    chk("drive_hot", oe0, oe_cnt);
    hot = 1'b0;
    $display("done: resp");
  endtask
  task automatic t_timeout();
    rx_ready = 1'b1;
    tick(4);
    rx_ready = 1'b0;
    header();
    m.hold(1'b1, TO + 500);
    m.send_byte(8'h35);
    tick(2 * P);
    chk("rx_after_timeout", 0, rx_valid);
    $display("done: timeout");
  endtask
  task automatic t_uv();
    sup_low = 1'b1;
    wake_ok = 1'b0;
    tick(20);
    chk("term_uv", 1, term);
    chk("rx_en_uv", 0, rx_en);
    sup_low = 1'b0;
    wake_ok = 1'b1;
    tick(20);
    chk("awake_uv", 1, awake);
    $display("done: uv");
  endtask
  task automatic t_sleep_wake();
    int k;
    for (k = 0; k < ID + TO + 100 && awake !== 1'b0; k++) tick(1);
    chk("sleep_idle", 0, awake);
    chk("rx_en_sleep", 0, rx_en);
    chk("term_sleep", 0, term);
    m.hold(1'b0, WAKE_FILT_CYC - 300);
    m.hold(1'b1, 300);
    chk("short_wake", 0, awake | por);
    m.hold(1'b0, WAKE_FILT_CYC + 100);
    chk("wake_pre_rise", 0, awake | por);
    m.hold(1'b1, 4);
    chk("por_on_rise", 1, por);
    for (k = 0; k < ST + 10 && awake !== 1'b1; k++) tick(1);
    chk("awake_por", 1, awake);
    sleep_cmd = 1'b1;
    tick(1);
    sleep_cmd = 1'b0;
    tick(4);
    chk("sleep_cmd", 0, awake);
    $display("done: sleep_wake");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(95_000 * 20);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    tick(2);
    t_reset();
    t_frame();
    t_resp();
    t_timeout();
    t_uv();
    t_sleep_wake();
    print_verdict();
  end
endmodule // tb_lsc_link
`default_nettype wire
